// ===== src/hdrins_top.sv
// HDR InfoFrame inserter: register slave, receive-side filter and merger.
// Assumes aclk is the transmit link-speed clock and tx_vsync is already
// resynchronised to it; all inputs are synchronous to aclk.
`default_nettype none

module hdrins_top (
    // Clock and reset
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    // Register bus write address and data
    input  wire logic [hdrins_pkg::ADDR_W-1:0]  awaddr,
    input  wire logic                           awvalid,
    output logic                                awready,
    input  wire logic [31:0]                    wdata,
    input  wire logic [3:0]                     wstrb,
    input  wire logic                           wvalid,
    output logic                                wready,
    // Register bus write response
    output logic [1:0]                          bresp,
    output logic                                bvalid,
    input  wire logic                           bready,
    // Register bus read
    input  wire logic [hdrins_pkg::ADDR_W-1:0]  araddr,
    input  wire logic                           arvalid,
    output logic                                arready,
    output logic [31:0]                         rdata,
    output logic [1:0]                          rresp,
    output logic                                rvalid,
    input  wire logic                           rready,
    // Frame timing
    input  wire logic                           tx_vsync,
    // Pass-through auxiliary stream in
    input  wire logic [hdrins_pkg::DATA_W-1:0]  pass_data,
    input  wire logic                           pass_valid,
    output logic                                pass_ready,
    input  wire logic                           pass_sop,
    input  wire logic                           pass_eop,
    // Merged auxiliary stream out
    output hdrins_pkg::hdrins_beat_t            aux_out,
    output logic                                aux_out_valid,
    input  wire logic                           aux_out_ready
);

    // Whole state of the block
    typedef struct packed {
        logic [hdrins_pkg::CFG_WORDS-1:0][31:0] cfg;        // Writable words
        logic                                   vsync_prev; // Edge detector
        logic                                   pending;    // Insertion owed
        logic                                   gen_active; // Sending local packet
        logic [hdrins_pkg::BEAT_IDX_W-1:0]      beat_idx;   // Local beat index
        logic                                   pass_busy;  // Inside a pass packet
        logic                                   dropping;   // Pass packet discarded
        hdrins_pkg::hdrins_beat_t               out_beat;   // Output slot
        logic                                   out_valid;
        logic                                   in_ready;
        logic                                   aw_held;
        logic [hdrins_pkg::ADDR_W-1:0]          aw_addr;
        logic                                   w_held;
        logic [31:0]                            w_data;
        logic [3:0]                             w_strb;
        logic                                   awready;
        logic                                   wready;
        logic                                   bvalid;
        logic [1:0]                             bresp;
        logic                                   arready;
        logic                                   rvalid;
        logic [31:0]                            rdata;
        logic [1:0]                             rresp;
        logic [15:0]                            insert_count; // Packets inserted
        logic [15:0]                            filter_count; // Packets removed
    } hdrins_state_t;

    hdrins_state_t                         st_reg;          // Registered state
    hdrins_state_t                         st_next;         // Next state
    hdrins_pkg::hdrins_meta_t              meta;            // Metadata view
    logic [hdrins_pkg::DATA_W-1:0]         gen_data;        // Generated beat
    logic [hdrins_pkg::PAYLOAD_W-1:0]      payload_bundle;  // Generated bundle
    logic                                  insert_en;       // Insertion enabled
    logic                                  filter_on;       // Removal active
    logic                                  take;            // Pass beat accepted
    logic                                  slot_free;       // Output slot loadable
    logic                                  generated_packet_valid; // Local beat offered
    logic                                  drop;            // Current pass beat dropped

    // Metadata taken from the configuration words
    assign meta.header_type_byte         = st_reg.cfg[hdrins_pkg::HEADER_IDX][hdrins_pkg::HDR_TYPE_LSB +: 8];
    assign meta.header_version_byte      = st_reg.cfg[hdrins_pkg::HEADER_IDX][hdrins_pkg::HDR_VER_LSB +: 8];
    assign meta.header_length_byte       = st_reg.cfg[hdrins_pkg::HEADER_IDX][hdrins_pkg::HDR_LEN_LSB +: 8];
    assign meta.transfer_function_code   = st_reg.cfg[hdrins_pkg::HEADER_IDX][hdrins_pkg::HDR_TFC_LSB +: 3];
    assign meta.metadata_descriptor_kind = st_reg.cfg[hdrins_pkg::HEADER_IDX][hdrins_pkg::HDR_DESC_LSB +: 3];
    assign meta.white_x             = st_reg.cfg[hdrins_pkg::WHITE_IDX][hdrins_pkg::LO_HALF_LSB +: 16];
    assign meta.white_y             = st_reg.cfg[hdrins_pkg::WHITE_IDX][hdrins_pkg::HI_HALF_LSB +: 16];
    assign meta.max_luminance       = st_reg.cfg[hdrins_pkg::LUMA_IDX][hdrins_pkg::LO_HALF_LSB +: 16];
    assign meta.min_luminance       = st_reg.cfg[hdrins_pkg::LUMA_IDX][hdrins_pkg::HI_HALF_LSB +: 16];
    assign meta.max_content_light   = st_reg.cfg[hdrins_pkg::LIGHT_IDX][hdrins_pkg::LO_HALF_LSB +: 16];
    assign meta.max_frame_avg_light = st_reg.cfg[hdrins_pkg::LIGHT_IDX][hdrins_pkg::HI_HALF_LSB +: 16];

    // One primary per word, x low half, y high half
    for (genvar p = 0; p < 3; p++) begin : g_prim
        assign meta.primary_x[p] = st_reg.cfg[hdrins_pkg::PRIM0_IDX+p][hdrins_pkg::LO_HALF_LSB +: 16];
        assign meta.primary_y[p] = st_reg.cfg[hdrins_pkg::PRIM0_IDX+p][hdrins_pkg::HI_HALF_LSB +: 16];
    end

    // Local packet generator
    hdrins_pkt_gen u_gen (
        .meta           (meta),
        .beat_index     (st_reg.beat_idx),
        .beat_data      (gen_data),
        .payload_bundle (payload_bundle)
    );

    // Control decode and stream qualifiers
    assign insert_en = st_reg.cfg[hdrins_pkg::CTRL_IDX][hdrins_pkg::CTRL_INSERT_BIT];
    assign filter_on = st_reg.cfg[hdrins_pkg::CTRL_IDX][hdrins_pkg::CTRL_FILTER_BIT] && insert_en;
    assign take      = pass_valid && st_reg.in_ready;
    assign slot_free = !st_reg.out_valid || aux_out_ready;
    assign generated_packet_valid = st_reg.gen_active && slot_free;
    assign drop = pass_sop ? (filter_on && pass_data[7:0] == meta.header_type_byte)
                           : st_reg.dropping;

    // Next-state logic for bus slave, scheduler and merger
    always_comb begin
        st_next = st_reg;
        // Write address and data are taken independently
        if (awvalid && st_reg.awready) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = awaddr;
            st_next.awready = 1'b0;
        end
        if (wvalid && st_reg.wready) begin
            st_next.w_held  = 1'b1;
            st_next.w_data  = wdata;
            st_next.w_strb  = wstrb;
            st_next.wready  = 1'b0;
        end
        // Response accepted: reopen both write channels
        if (st_reg.bvalid && bready) begin
            st_next.bvalid  = 1'b0;
            st_next.awready = 1'b1;
            st_next.wready  = 1'b1;
        end
        // Both halves present: perform the write
        if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = hdrins_pkg::RESP_OKAY;
            if (st_reg.aw_addr[7:5] == 3'h0) begin
                for (int b = 0; b < 4; b++) begin
                    if (st_reg.w_strb[b]) begin
                        st_next.cfg[st_reg.aw_addr[4:2]][b*8 +: 8] = st_reg.w_data[b*8 +: 8];
                    end
                end
            end else if (st_reg.aw_addr[7:2] == hdrins_pkg::STATUS_OFFSET[7:2]) begin
                // Status is read-only, the write is ignored
                st_next.bresp = hdrins_pkg::RESP_OKAY;
            end else begin
                st_next.bresp = hdrins_pkg::RESP_SLVERR;
            end
        end
        // Read answer is loaded when the address is taken
        if (arvalid && st_reg.arready) begin
            st_next.arready = 1'b0;
            st_next.rvalid  = 1'b1;
            st_next.rresp   = hdrins_pkg::RESP_OKAY;
            if (araddr[7:5] == 3'h0) begin
                st_next.rdata = st_reg.cfg[araddr[4:2]];
            end else if (araddr[7:2] == hdrins_pkg::STATUS_OFFSET[7:2]) begin
                st_next.rdata = {st_reg.filter_count, st_reg.insert_count};
            end else begin
                st_next.rdata = 32'h0000_0000;
                st_next.rresp = hdrins_pkg::RESP_SLVERR;
            end
        end
        if (st_reg.rvalid && rready) begin
            st_next.rvalid  = 1'b0;
            st_next.arready = 1'b1;
        end

        // Output slot empties on a downstream handshake
        if (st_reg.out_valid && aux_out_ready) begin
            st_next.out_valid = 1'b0;
        end
        st_next.vsync_prev = tx_vsync;

        // Merge: pass beat, then local beats, then start of local packet
        if (take) begin
            st_next.pass_busy = !pass_eop;
            if (pass_sop) begin
                st_next.dropping = drop;
            end
            if (!drop) begin
                st_next.out_beat  = '{data: pass_data, channel: hdrins_pkg::PASS_CHANNEL,
                                      sop: pass_sop, eop: pass_eop};
                st_next.out_valid = 1'b1;
            end else if (pass_sop) begin
                st_next.filter_count = st_reg.filter_count + 16'h0001;
            end
        end else if (st_reg.gen_active) begin
            if (generated_packet_valid) begin
                st_next.out_beat  = '{data: gen_data, channel: hdrins_pkg::GEN_CHANNEL,
                                      sop: st_reg.beat_idx == 3'h0,
                                      eop: st_reg.beat_idx == hdrins_pkg::LAST_BEAT};
                st_next.out_valid = 1'b1;
                st_next.beat_idx  = st_reg.beat_idx + 3'h1;
                if (st_reg.beat_idx == hdrins_pkg::LAST_BEAT) begin
                    st_next.gen_active   = 1'b0;
                    st_next.insert_count = st_reg.insert_count + 16'h0001;
                end
            end
        end else if (st_reg.pending && !st_reg.pass_busy && insert_en) begin
            st_next.gen_active = 1'b1;
            st_next.beat_idx   = 3'h0;
            st_next.pending    = 1'b0;
        end

        // Disabled insertion owes nothing; a new edge wins over the clear
        if (!insert_en) begin
            st_next.pending = 1'b0;
        end
        if (tx_vsync && !st_reg.vsync_prev && insert_en) begin
            st_next.pending = 1'b1;
        end

        // Offer a pass beat only when the slot will be empty and no switch is due
        st_next.in_ready = !st_next.out_valid && !st_next.gen_active &&
                           !(st_next.pending && !st_next.pass_busy && insert_en);

        // Synchronous reset
        if (!aresetn) begin
            st_next = '0;
            st_next.cfg[hdrins_pkg::CTRL_IDX] = hdrins_pkg::CTRL_RESET;
            for (int i = 1; i < hdrins_pkg::CFG_WORDS; i++) begin
                st_next.cfg[i] = hdrins_pkg::CFG_RESET;
            end
            st_next.awready  = 1'b1;
            st_next.wready   = 1'b1;
            st_next.arready  = 1'b1;
        end
    end

    // State register on the link-speed clock
    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    // Outputs straight from the state register
    assign awready       = st_reg.awready;
    assign wready        = st_reg.wready;
    assign bvalid        = st_reg.bvalid;
    assign bresp         = st_reg.bresp;
    assign arready       = st_reg.arready;
    assign rvalid        = st_reg.rvalid;
    assign rdata         = st_reg.rdata;
    assign rresp         = st_reg.rresp;
    assign pass_ready    = st_reg.in_ready;
    assign aux_out       = st_reg.out_beat;
    assign aux_out_valid = st_reg.out_valid;

    // Checks on the block's own behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    vsync_sched_a: assert property (
        tx_vsync && !st_reg.vsync_prev && insert_en |=> st_reg.pending || st_reg.gen_active)
        else $error("Vsync edge did not schedule an insertion");

    out_hold_a: assert property (
        aux_out_valid && !aux_out_ready |=> aux_out_valid && $stable(aux_out))
        else $error("Output beat changed under backpressure");

    filter_drop_a: assert property (
        take && pass_sop && filter_on && pass_data[7:0] == meta.header_type_byte
        |=> !aux_out_valid)
        else $error("Incoming InfoFrame was not removed");

    filter_off_a: assert property (
        take && !filter_on && (pass_sop || !st_reg.dropping)
        |=> aux_out_valid && aux_out.data == $past(pass_data))
        else $error("Beat lost while removal disabled");

    gen_off_a: assert property (
        !st_reg.gen_active && !insert_en |=> !st_reg.gen_active && !st_reg.pending)
        else $error("Insertion started while disabled");

    gen_boundary_a: assert property (
        st_reg.gen_active |-> !st_reg.pass_busy && !pass_ready)
        else $error("Local packet started inside a pass packet");

    gen_length_a: assert property (
        $rose(st_reg.gen_active) |-> ##[5:400] $fell(st_reg.gen_active))
        else $error("Local packet did not finish");

    gen_eop_a: assert property (
        $past(generated_packet_valid)
        |-> aux_out_valid && aux_out.channel == hdrins_pkg::GEN_CHANNEL &&
            aux_out.sop == ($past(st_reg.beat_idx) == 3'h0) &&
            aux_out.eop == ($past(st_reg.beat_idx) == hdrins_pkg::LAST_BEAT))
        else $error("Local packet marker at wrong beat");

    reserved_zero_a: assert property (
        payload_bundle[223:208] == 16'h0000 && payload_bundle[7:3] == 5'h00 &&
        payload_bundle[15:11] == 5'h00)
        else $error("Reserved or padding payload bits not zero");

    reset_clear_a: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> !aux_out_valid && !st_reg.pending && !st_reg.gen_active)
        else $error("Reset left valid or pending set");

endmodule

`default_nettype wire

// ===== pkg/hdrins_pkg.sv
// Shared constants and carrier types for the HDR InfoFrame inserter.
// Assumes a single link-speed clock and a synchronous active-low reset.
`default_nettype none

package hdrins_pkg;

    // Stream widths and generated packet shape
    localparam int          DATA_W       = 72;     // Auxiliary data word
    localparam int          CHAN_W       = 11;     // Channel field
    localparam int          PAYLOAD_W    = 224;    // Payload bundle
    localparam int          SUBPKT_W     = 56;     // Payload bits per body beat
    localparam int          SUBPKTS      = 4;      // Body beats per packet
    localparam int          BEAT_IDX_W   = 3;      // Beat counter width
    localparam logic [2:0]  LAST_BEAT    = 3'h4;   // Header beat plus four body beats

    // Channel codes that mark the source of each output beat
    localparam logic [10:0] PASS_CHANNEL = 11'h000;
    localparam logic [10:0] GEN_CHANNEL  = 11'h001;

    // Register bus shape
    localparam int          ADDR_W       = 8;
    localparam int          CFG_WORDS    = 8;

    // Register byte offsets
    localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
    localparam logic [7:0]  HEADER_OFFSET = 8'h04;
    localparam logic [7:0]  PRIM0_OFFSET  = 8'h08;
    localparam logic [7:0]  PRIM1_OFFSET  = 8'h0c;
    localparam logic [7:0]  PRIM2_OFFSET  = 8'h10;
    localparam logic [7:0]  WHITE_OFFSET  = 8'h14;
    localparam logic [7:0]  LUMA_OFFSET   = 8'h18;
    localparam logic [7:0]  LIGHT_OFFSET  = 8'h1c;
    localparam logic [7:0]  STATUS_OFFSET = 8'h20;

    // Word indices of the configuration words
    localparam int          CTRL_IDX   = 0;
    localparam int          HEADER_IDX = 1;
    localparam int          PRIM0_IDX  = 2;
    localparam int          WHITE_IDX  = 5;
    localparam int          LUMA_IDX   = 6;
    localparam int          LIGHT_IDX  = 7;

    // Field positions
    localparam int          CTRL_INSERT_BIT = 0;
    localparam int          CTRL_FILTER_BIT = 1;
    localparam int          HDR_TYPE_LSB    = 0;
    localparam int          HDR_VER_LSB     = 8;
    localparam int          HDR_LEN_LSB     = 16;
    localparam int          HDR_TFC_LSB     = 24;
    localparam int          HDR_DESC_LSB    = 28;
    localparam int          LO_HALF_LSB     = 0;
    localparam int          HI_HALF_LSB     = 16;

    // Values after reset
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam logic [31:0] CFG_RESET  = 32'h0000_0000;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // One auxiliary stream beat
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [CHAN_W-1:0] channel;
        logic              sop;
        logic              eop;
    } hdrins_beat_t;

    // Metadata that forms the local InfoFrame
    typedef struct packed {
        logic [7:0]       header_type_byte;
        logic [7:0]       header_version_byte;
        logic [7:0]       header_length_byte;
        logic [2:0]       transfer_function_code;
        logic [2:0]       metadata_descriptor_kind;
        logic [2:0][15:0] primary_x;
        logic [2:0][15:0] primary_y;
        logic [15:0]      white_x;
        logic [15:0]      white_y;
        logic [15:0]      max_luminance;
        logic [15:0]      min_luminance;
        logic [15:0]      max_content_light;
        logic [15:0]      max_frame_avg_light;
    } hdrins_meta_t;

endpackage

`default_nettype wire

// ===== src/hdrins_pkt_gen.sv
// Packet generator: forms the payload bundle and the beat for a beat index.
// Assumes the caller steps the index from 0 to the last beat.
`default_nettype none

module hdrins_pkt_gen (
    // Metadata in
    input  wire hdrins_pkg::hdrins_meta_t         meta,
    // Beat selection
    input  wire logic [hdrins_pkg::BEAT_IDX_W-1:0] beat_index,
    // Generated beat and bundle
    output logic [hdrins_pkg::DATA_W-1:0]          beat_data,
    output logic [hdrins_pkg::PAYLOAD_W-1:0]       payload_bundle
);

    // Body slices of the bundle, one per body beat
    logic [hdrins_pkg::SUBPKTS-1:0][hdrins_pkg::SUBPKT_W-1:0] subpkt;
    logic [1:0]                                               body_sel;

    // Bundle with data byte one lowest, 16-bit values low byte first
    assign payload_bundle = {
        16'h0000,
        meta.max_frame_avg_light, meta.max_content_light,
        meta.min_luminance, meta.max_luminance,
        meta.white_y, meta.white_x,
        meta.primary_y[2], meta.primary_x[2],
        meta.primary_y[1], meta.primary_x[1],
        meta.primary_y[0], meta.primary_x[0],
        5'h00, meta.metadata_descriptor_kind,
        5'h00, meta.transfer_function_code
    };

    // Cut the bundle into body beats
    for (genvar k = 0; k < hdrins_pkg::SUBPKTS; k++) begin : g_sub
        assign subpkt[k] = payload_bundle[k*hdrins_pkg::SUBPKT_W +: hdrins_pkg::SUBPKT_W];
    end

    assign body_sel = 2'(beat_index - 3'h1);

    // Header beat carries the three header bytes, others carry a slice
    always_comb begin
        if (beat_index == 3'h0) begin
            beat_data = {48'h0, meta.header_length_byte,
                         meta.header_version_byte,
                         meta.header_type_byte};
        end else begin
            beat_data = {16'h0000, subpkt[body_sel]};
        end
    end

endmodule

`default_nettype wire

// ===== dv/hdrins_sink.sv
// Transmitter aux port model: paces ready and records accepted beats.
// Assumes it shares aclk with the inserter.
`default_nettype none
module hdrins_sink (
    // Clock and pacing
    input  wire logic                     aclk,
    input  wire logic                     slow,
    // Merged stream
    input  wire hdrins_pkg::hdrins_beat_t beat,
    input  wire logic                     beat_valid,
    output logic                          beat_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    hdrins_pkg::hdrins_beat_t got[$];  // Accepted beats in order
    initial beat_ready = 1'b0;
    // Ready each cycle, or every other cycle when slow
    always @(posedge aclk) begin
        beat_ready <= slow ? !beat_ready : 1'b1;
        if (beat_valid && beat_ready) got.push_back(beat);
    end
endmodule
`default_nettype wire

// ===== dv/hdrins_top_bench.sv
// Self-checking bench for the inserter: bus, insertion, filtering.
// Assumes the sink model records every merged beat.
`default_nettype none
module hdrins_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tx_vsync, slow;
    logic pass_valid, pass_sop, pass_eop, awready, wready, bvalid, arready, rvalid;
    logic pass_ready, aux_out_valid, aux_out_ready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [71:0] pass_data;
    logic [33:0] rd_got;                 // Last read response and data
    logic [1:0] b_got;                   // Last write response
    hdrins_pkg::hdrins_beat_t aux_out;
    int n_mismatch, n_compared;
    hdrins_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .tx_vsync, .pass_data, .pass_valid, .pass_ready,
        .pass_sop, .pass_eop, .aux_out, .aux_out_valid, .aux_out_ready);
    hdrins_sink i_sink (.aclk, .slow, .beat(aux_out), .beat_valid(aux_out_valid),
        .beat_ready(aux_out_ready));
    initial begin
        aclk = 0;
        forever #25 aclk = ~aclk;
    end
    task automatic chk(string nm, logic [84:0] e, logic [84:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bus write: each channel released as soon as it is taken
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        b_got = bresp;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        rd_got = {rresp, rdata};
    endtask
    task automatic snd(logic [71:0] d, logic s, logic e);
        @(posedge aclk);
        {pass_data, pass_sop, pass_eop, pass_valid} <= {d, s, e, 1'b1};
        do @(posedge aclk); while (!pass_ready);
        pass_valid <= 0;
    endtask
    task automatic pulse(int idle);
        @(posedge aclk) tx_vsync <= 1;
        @(posedge aclk) tx_vsync <= 0;
        repeat (idle) @(posedge aclk);
    endtask
    task automatic t_regs;
        rd(hdrins_pkg::CTRL_OFFSET);
        chk("ctrl", {hdrins_pkg::RESP_OKAY, hdrins_pkg::CTRL_RESET}, rd_got);
        rd(8'h40);
        chk("unmapped", {hdrins_pkg::RESP_SLVERR, 32'h0}, rd_got);
    endtask
    // Generated packet under a slow sink: header beat, layout, reserved bytes
    task automatic t_insert;
        wr(hdrins_pkg::HEADER_OFFSET, 32'h021a_0187);
        wr(hdrins_pkg::PRIM0_OFFSET, 32'h5678_1234);
        wr(hdrins_pkg::LIGHT_OFFSET, 32'hbbbb_aaaa);
        slow <= 1;
        pulse(60);
        chk("count", 5, i_sink.got.size());
        chk("b0", {48'h0, 24'h1a_0187, 11'h1, 2'b10}, i_sink.got[0]);
        chk("b1", {72'h00_5678_1234_0002, 11'h1, 2'b00}, i_sink.got[1]);
        chk("b4", {72'h0000_bbbb_aaaa_00, 11'h1, 2'b01}, i_sink.got[4]);
        slow <= 0;
    endtask
    // Incoming packet of the same type: dropped, then passed with insertion off
    task automatic t_filter;
        snd(72'h87, 1, 0);
        snd(72'h55, 0, 1);
        repeat (20) @(posedge aclk);
        chk("dropped", 5, i_sink.got.size());
        wr(hdrins_pkg::CTRL_OFFSET, 32'h2);
        snd(72'h87, 1, 0);
        snd(72'h55, 0, 1);
        pulse(30);
        chk("passed", 7, i_sink.got.size());
        chk("p0", {72'h87, 11'h0, 2'b10}, i_sink.got[5]);
    endtask
    // Pass packet in progress delays the local packet; counters read back
    task automatic t_boundary;
        wr(hdrins_pkg::CTRL_OFFSET, 32'h1);
        chk("ctrl wr", hdrins_pkg::RESP_OKAY, b_got);
        snd(72'h87, 1, 0);
        pulse(5);
        snd(72'h44, 0, 1);
        repeat (20) @(posedge aclk);
        chk("merged", 14, i_sink.got.size());
        chk("m0", {72'h87, 11'h0, 2'b10}, i_sink.got[7]);
        chk("m1", {72'h44, 11'h0, 2'b01}, i_sink.got[8]);
        chk("m2", {48'h0, 24'h1a_0187, 11'h1, 2'b10}, i_sink.got[9]);
        rd(hdrins_pkg::STATUS_OFFSET);
        chk("status", {hdrins_pkg::RESP_OKAY, 32'h0001_0002}, rd_got);
    endtask
    // Reset right after a vsync edge drops the owed insertion
    task automatic t_reset;
        pulse(0);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        repeat (20) @(posedge aclk);
        chk("after reset", 14, i_sink.got.size());
        rd(hdrins_pkg::STATUS_OFFSET);
        chk("status reset", {hdrins_pkg::RESP_OKAY, 32'h0}, rd_got);
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, tx_vsync, slow} = 0;
        {pass_valid, pass_sop, pass_eop, awaddr, araddr, wdata, pass_data} = 0;
        wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        t_regs;
        t_insert;
        t_filter;
        t_boundary;
        t_reset;
        conclude;
    end
    initial begin
        #150000;
        n_mismatch++;
        conclude;
    end
endmodule
`default_nettype wire
